// ---- rtl/vsfr_pkg.sv ----
// Constants and types shared by the valley-switching frequency reduction core.
// Assumes a single 20 MHz clock; all times are turned into cycle counts here.
package vsfr_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // Feedback evaluation period of the valley counter.
  localparam int EVAL_PERIOD_MS = 48;
  localparam int EVAL_CYCLES    = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // Soft-start: total time split into equal steps of the current-sense limit.
  localparam int SS_TIME_MS     = 12;
  localparam int SS_STEPS       = 4;
  localparam int SS_STEP_CYCLES = SS_TIME_MS * 1000000 / CLK_PERIOD_NS / SS_STEPS;

  // Off-time and on-time limits; least times round up to whole cycles.
  localparam int MAX_OFF_NS     = 50000;
  localparam int MAX_OFF_CYCLES = (MAX_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RS_SHORT_NS    = 2500;
  localparam int RS_SHORT_CYCLES = (RS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RS_LONG_NS     = 5000;
  localparam int RS_LONG_CYCLES = (RS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_NS         = 300;
  localparam int LEB_CYCLES     = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_BLANK_NS   = 1000;
  localparam int OVP_BLANK_CYCLES = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width that holds every timer above.
  localparam int CNT_W = 20;

  // Valley and zero-crossing counter limits and reset values.
  localparam logic [2:0] VALLEY_MIN  = 3'h1;
  localparam logic [2:0] VALLEY_MAX  = 3'h7;
  localparam logic [2:0] VALLEY_INIT = 3'h1;
  localparam logic [2:0] ZC_MAX      = 3'h7;
  localparam logic [2:0] ZC_INIT     = 3'h0;
  localparam logic [1:0] SS_STEP_LAST = 2'h3;

  // Bit positions of the synchronised comparator vector.
  localparam int IDX_FB_LOW   = 0;
  localparam int IDX_FB_HIGH  = 1;
  localparam int IDX_FB_RESET = 2;
  localparam int IDX_LINE_HI  = 3;
  localparam int IDX_ZC_BELOW = 4;
  localparam int IDX_ZC_OVP   = 5;
  localparam int IDX_ZC_RS    = 6;
  localparam int IDX_SUP_ON   = 7;
  localparam int IDX_CS_TRIP  = 8;
  localparam int N_SYNC       = 9;

  typedef enum logic [3:0] {
    ST_PRECHARGE = 4'h1,
    ST_ON        = 4'h2,
    ST_OFF       = 4'h4,
    ST_LATCHED   = 4'h8
  } vsfr_state_t;

endpackage

// ---- rtl/vsfr_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous comparator levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
module vsfr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } vsfr_sync_regs_t;

  vsfr_sync_regs_t sy_r;
  vsfr_sync_regs_t sy_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("vsfr_sync: WIDTH must be at least 1.");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    sy_nxt    = sy_r;
    sy_nxt.s1 = d_in;
    sy_nxt.s2 = sy_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign q_out = sy_r.s2;

endmodule

// ---- rtl/vsfr_core.sv ----
// Digital control core of a quasi-resonant flyback controller.
// Assumes analog comparators deliver asynchronous levels and the power stage
// follows GATE_DRIVE; RESETN is the supply-on reset of the whole device.
`timescale 1ns/1ps
module vsfr_core #(
  parameter int EVAL_CYC     = vsfr_pkg::EVAL_CYCLES,
  parameter int SS_STEP_CYC  = vsfr_pkg::SS_STEP_CYCLES,
  parameter int MAX_OFF_CYC  = vsfr_pkg::MAX_OFF_CYCLES,
  parameter int RS_SHORT_CYC = vsfr_pkg::RS_SHORT_CYCLES,
  parameter int RS_LONG_CYC  = vsfr_pkg::RS_LONG_CYCLES,
  parameter int LEB_CYC      = vsfr_pkg::LEB_CYCLES,
  parameter int OVP_CYC      = vsfr_pkg::OVP_BLANK_CYCLES
) (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       FB_ABOVE_LOW,
  input  wire logic       FB_ABOVE_HIGH,
  input  wire logic       FB_ABOVE_RESET,
  input  wire logic       LINE_HIGH,
  input  wire logic       ZC_BELOW_ZERO,
  input  wire logic       ZC_ABOVE_OVP,
  input  wire logic       ZC_ABOVE_RS,
  input  wire logic       SUPPLY_ON,
  input  wire logic       CS_TRIP,
  output logic            GATE_DRIVE,
  output logic            PRECHARGE_EN,
  output logic [1:0]      CS_LIMIT_STEP,
  output logic            SOFTSTART_DONE,
  output logic            LATCHED_OFF,
  output logic [2:0]      VALLEY_COUNT,
  output logic [2:0]      ZC_COUNT,
  output logic            THR_SEL_HIGH_LINE
);

  localparam int CW = vsfr_pkg::CNT_W;

  localparam logic [CW-1:0] EVAL_LAST  = CW'(EVAL_CYC - 1);
  localparam logic [CW-1:0] SS_LAST    = CW'(SS_STEP_CYC - 1);
  localparam logic [CW-1:0] MAXOFF_LST = CW'(MAX_OFF_CYC - 1);
  localparam logic [CW-1:0] RS_S_LAST  = CW'(RS_SHORT_CYC - 1);
  localparam logic [CW-1:0] RS_L_LAST  = CW'(RS_LONG_CYC - 1);
  localparam logic [CW-1:0] LEB_LAST   = CW'(LEB_CYC - 1);
  localparam logic [CW-1:0] OVP_LAST   = CW'(OVP_CYC - 1);
  localparam logic [CW-1:0] CNT_TOP    = '1;

  if (EVAL_CYC < 1 || EVAL_CYC >= (1 << CW)) begin : g_chk_eval
    $error("vsfr_core: EVAL_CYC out of range.");
  end
  if (SS_STEP_CYC < 1 || SS_STEP_CYC >= (1 << CW)) begin : g_chk_ss
    $error("vsfr_core: SS_STEP_CYC out of range.");
  end
  if (MAX_OFF_CYC < 1 || MAX_OFF_CYC >= (1 << CW)) begin : g_chk_off
    $error("vsfr_core: MAX_OFF_CYC out of range.");
  end
  if (RS_SHORT_CYC < 1 || RS_LONG_CYC < RS_SHORT_CYC || RS_LONG_CYC >= MAX_OFF_CYC)
  begin : g_chk_rs
    $error("vsfr_core: ringing suppression counts out of range.");
  end
  if (LEB_CYC < 1 || LEB_CYC >= (1 << CW)) begin : g_chk_leb
    $error("vsfr_core: LEB_CYC out of range.");
  end
  if (OVP_CYC < 1 || OVP_CYC >= (1 << CW)) begin : g_chk_ovp
    $error("vsfr_core: OVP_CYC out of range.");
  end

  typedef struct packed {
    vsfr_pkg::vsfr_state_t state;
    logic [CW-1:0]         eval_cnt;
    logic [CW-1:0]         ss_cnt;
    logic [CW-1:0]         tmr;
    logic [CW-1:0]         ovp_cnt;
    logic [1:0]            ss_step;
    logic                  ss_done;
    logic [2:0]            valley;
    logic [2:0]            zc_cnt;
    logic                  zc_below_d;
    logic                  seen_low;
    logic                  seen_high;
    logic                  seen_reset;
    logic                  thr_sel;
    logic                  gate;
    logic                  precharge;
    logic                  latched;
  } vsfr_regs_t;

  vsfr_regs_t                      cr_r;
  vsfr_regs_t                      cr_nxt;
  logic [vsfr_pkg::N_SYNC-1:0]     raw_in;
  logic [vsfr_pkg::N_SYNC-1:0]     syn;

  assign raw_in = {CS_TRIP, SUPPLY_ON, ZC_ABOVE_RS, ZC_ABOVE_OVP, ZC_BELOW_ZERO,
                   LINE_HIGH, FB_ABOVE_RESET, FB_ABOVE_HIGH, FB_ABOVE_LOW};

  vsfr_sync #(
    .WIDTH (vsfr_pkg::N_SYNC)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .d_in  (raw_in),
    .q_out (syn)
  );

  logic          fb_low;
  logic          fb_high;
  logic          fb_reset;
  logic          zc_fall;
  logic          cs_trip;
  logic [CW-1:0] rs_last;

  assign fb_low   = syn[vsfr_pkg::IDX_FB_LOW];
  assign fb_high  = syn[vsfr_pkg::IDX_FB_HIGH];
  assign fb_reset = syn[vsfr_pkg::IDX_FB_RESET];
  assign cs_trip  = syn[vsfr_pkg::IDX_CS_TRIP];

  assign zc_fall = syn[vsfr_pkg::IDX_ZC_BELOW] & ~cr_r.zc_below_d;

  // A low ringing level means a slow ring, so the longer window applies.
  assign rs_last = syn[vsfr_pkg::IDX_ZC_RS] ? RS_S_LAST : RS_L_LAST;

  always_comb begin
    cr_nxt            = cr_r;
    cr_nxt.zc_below_d = syn[vsfr_pkg::IDX_ZC_BELOW];

    // Evaluation period and valley counter.
    if (cr_r.state == vsfr_pkg::ST_PRECHARGE) begin
      cr_nxt.valley     = vsfr_pkg::VALLEY_INIT;
      cr_nxt.eval_cnt   = '0;
      cr_nxt.seen_low   = 1'b0;
      cr_nxt.seen_high  = 1'b0;
      cr_nxt.seen_reset = 1'b0;
      cr_nxt.thr_sel    = syn[vsfr_pkg::IDX_LINE_HI];
    end else if (cr_r.eval_cnt == EVAL_LAST) begin
      cr_nxt.eval_cnt = '0;
      if (cr_r.seen_reset || fb_reset) begin
        cr_nxt.valley = vsfr_pkg::VALLEY_MIN;
      end else if (cr_r.seen_high || fb_high) begin
        if (cr_r.valley > vsfr_pkg::VALLEY_MIN) begin
          cr_nxt.valley = cr_r.valley - 3'h1;
        end
      end else if (cr_r.seen_low || fb_low) begin
        cr_nxt.valley = cr_r.valley;
      end else begin
        if (cr_r.valley < vsfr_pkg::VALLEY_MAX) begin
          cr_nxt.valley = cr_r.valley + 3'h1;
        end
      end
      cr_nxt.seen_low   = 1'b0;
      cr_nxt.seen_high  = 1'b0;
      cr_nxt.seen_reset = 1'b0;
      // threshold set follows line
      // Switching the threshold pair only at a boundary keeps one period coherent.
      cr_nxt.thr_sel = syn[vsfr_pkg::IDX_LINE_HI];
    end else begin
      cr_nxt.eval_cnt = cr_r.eval_cnt + 1'b1;
      cr_nxt.seen_low   = cr_r.seen_low | fb_low;
      cr_nxt.seen_high  = cr_r.seen_high | fb_high;
      cr_nxt.seen_reset = cr_r.seen_reset | fb_reset;
    end

    if (cr_r.state == vsfr_pkg::ST_PRECHARGE) begin
      cr_nxt.ss_cnt  = '0;
      cr_nxt.ss_step = 2'h0;
      cr_nxt.ss_done = 1'b0;
    end else if (!cr_r.ss_done) begin
      if (cr_r.ss_cnt == SS_LAST) begin
        cr_nxt.ss_cnt = '0;
        if (cr_r.ss_step == vsfr_pkg::SS_STEP_LAST) begin
          cr_nxt.ss_done = 1'b1;
        end else begin
          cr_nxt.ss_step = cr_r.ss_step + 2'h1;
        end
      end else begin
        cr_nxt.ss_cnt = cr_r.ss_cnt + 1'b1;
      end
    end

    if (cr_r.tmr != CNT_TOP) begin
      cr_nxt.tmr = cr_r.tmr + 1'b1;
    end

    case (cr_r.state)
      vsfr_pkg::ST_PRECHARGE: begin
        cr_nxt.gate      = 1'b0;
        cr_nxt.precharge = 1'b1;
        if (syn[vsfr_pkg::IDX_SUP_ON]) begin
          cr_nxt.precharge = 1'b0;
          cr_nxt.state     = vsfr_pkg::ST_ON;
          cr_nxt.gate      = 1'b1;
          cr_nxt.tmr       = '0;
          cr_nxt.zc_cnt    = vsfr_pkg::ZC_INIT;
        end
      end
      vsfr_pkg::ST_ON: begin
        // analog turn-off
        // The blanking ignores the turn-on spike on the current-sense path.
        if (cr_r.tmr >= LEB_LAST && cs_trip) begin
          cr_nxt.gate    = 1'b0;
          cr_nxt.state   = vsfr_pkg::ST_OFF;
          cr_nxt.tmr     = '0;
          cr_nxt.ovp_cnt = '0;
        end
      end
      vsfr_pkg::ST_OFF: begin
        if (zc_fall && cr_r.zc_cnt != vsfr_pkg::ZC_MAX) begin
          cr_nxt.zc_cnt = cr_r.zc_cnt + 3'h1;
        end
        if (syn[vsfr_pkg::IDX_ZC_OVP]) begin
          cr_nxt.ovp_cnt = cr_r.ovp_cnt + 1'b1;
        end else begin
          cr_nxt.ovp_cnt = '0;
        end
        if (syn[vsfr_pkg::IDX_ZC_OVP] && cr_r.ovp_cnt == OVP_LAST) begin
          cr_nxt.state   = vsfr_pkg::ST_LATCHED;
          cr_nxt.latched = 1'b1;
          cr_nxt.gate    = 1'b0;
        end else if (cr_r.tmr >= MAXOFF_LST) begin
          cr_nxt.state  = vsfr_pkg::ST_ON;
          cr_nxt.gate   = 1'b1;
          cr_nxt.tmr    = '0;
          cr_nxt.zc_cnt = vsfr_pkg::ZC_INIT;
        end else if (cr_r.tmr >= rs_last && cr_r.zc_cnt >= cr_r.valley) begin
          cr_nxt.state  = vsfr_pkg::ST_ON;
          cr_nxt.gate   = 1'b1;
          cr_nxt.tmr    = '0;
          cr_nxt.zc_cnt = vsfr_pkg::ZC_INIT;
        end
      end
      vsfr_pkg::ST_LATCHED: begin
        cr_nxt.gate    = 1'b0;
        cr_nxt.latched = 1'b1;
      end
      default: begin
        // An illegal code shuts the switch down rather than guessing.
        cr_nxt.state   = vsfr_pkg::ST_LATCHED;
        cr_nxt.gate    = 1'b0;
        cr_nxt.latched = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cr_r           <= '0;
      cr_r.state     <= vsfr_pkg::ST_PRECHARGE;
      cr_r.valley    <= vsfr_pkg::VALLEY_INIT;
      cr_r.zc_cnt    <= vsfr_pkg::ZC_INIT;
      cr_r.precharge <= 1'b1;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  assign GATE_DRIVE        = cr_r.gate;
  assign PRECHARGE_EN      = cr_r.precharge;
  assign CS_LIMIT_STEP     = cr_r.ss_step;
  assign SOFTSTART_DONE    = cr_r.ss_done;
  assign LATCHED_OFF       = cr_r.latched;
  assign VALLEY_COUNT      = cr_r.valley;
  assign ZC_COUNT          = cr_r.zc_cnt;
  assign THR_SEL_HIGH_LINE = cr_r.thr_sel;

endmodule

// ---- tb/vsfr_core_chk.sv ----
// Assertions on the ports of the valley-switching core.
// Assumes one clock domain and the asynchronous active-low supply reset.
`timescale 1ns/1ps
module vsfr_core_chk #(
  parameter int MAX_OFF_CYC  = 1000,
  parameter int RS_SHORT_CYC = 50,
  parameter int OVP_CYC      = 20
) (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       ZC_ABOVE_OVP,
  input wire logic       GATE_DRIVE,
  input wire logic       PRECHARGE_EN,
  input wire logic [1:0] CS_LIMIT_STEP,
  input wire logic       LATCHED_OFF,
  input wire logic [2:0] VALLEY_COUNT,
  input wire logic [2:0] ZC_COUNT
);
  typedef struct packed {
    logic [15:0] off;
    logic [7:0]  ovp;
  } vsfr_chk_t;
  vsfr_chk_t h_r;
  vsfr_chk_t h_nxt;
  // Off time restarts in precharge, so the first pulse after start-up is not judged.
  always_comb begin
    h_nxt = h_r;
    h_nxt.off = (GATE_DRIVE || PRECHARGE_EN) ? 16'h0 : h_r.off + {15'h0, ~&h_r.off};
    h_nxt.ovp = ZC_ABOVE_OVP ? h_r.ovp + {7'h0, ~&h_r.ovp} : 8'h0;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  pre_hold_a: assert property (
    PRECHARGE_EN |-> !GATE_DRIVE && CS_LIMIT_STEP == 2'h0 && VALLEY_COUNT == 3'h1)
    else $error("output active in precharge");
  ss_step_a: assert property (
    $changed(CS_LIMIT_STEP) |-> CS_LIMIT_STEP == $past(CS_LIMIT_STEP) + 2'h1)
    else $error("limit step skipped");
  valley_step_a: assert property ($changed(VALLEY_COUNT) |-> VALLEY_COUNT != 3'h0 &&
    (VALLEY_COUNT == $past(VALLEY_COUNT) + 3'h1 || VALLEY_COUNT == $past(VALLEY_COUNT) - 3'h1
     || VALLEY_COUNT == 3'h1))
    else $error("valley count jumped");
  zc_on_a: assert property (GATE_DRIVE |-> ZC_COUNT == 3'h0)
    else $error("crossing count not clear");
  zc_step_a: assert property ($changed(ZC_COUNT) |->
    $past(ZC_COUNT) != 3'h7 && ZC_COUNT == $past(ZC_COUNT) + 3'h1 || $rose(GATE_DRIVE))
    else $error("crossing count stepped wrong");
  rs_window_a: assert property (
    $rose(GATE_DRIVE) && !$fell(PRECHARGE_EN) |-> h_r.off >= RS_SHORT_CYC)
    else $error("turn-on inside ringing window");
  valley_on_a: assert property ($rose(GATE_DRIVE) && !$fell(PRECHARGE_EN) |->
    $past(ZC_COUNT) >= $past(VALLEY_COUNT) || h_r.off >= MAX_OFF_CYC)
    else $error("turn-on without cause");
  max_off_a: assert property (!LATCHED_OFF |-> h_r.off <= MAX_OFF_CYC)
    else $error("off time too long");
  latch_hold_a: assert property (LATCHED_OFF |-> !GATE_DRIVE ##1 LATCHED_OFF)
    else $error("latch-off released");
  ovp_blank_a: assert property ($rose(LATCHED_OFF) |-> h_r.ovp >= OVP_CYC)
    else $error("latch-off before blanking");
endmodule

bind vsfr_core vsfr_core_chk #(
  .MAX_OFF_CYC(MAX_OFF_CYC),
  .RS_SHORT_CYC(RS_SHORT_CYC),
  .OVP_CYC(OVP_CYC)
) u_chk (.CLK(CLK), .RESETN(RESETN), .ZC_ABOVE_OVP(ZC_ABOVE_OVP), .GATE_DRIVE(GATE_DRIVE),
  .PRECHARGE_EN(PRECHARGE_EN), .CS_LIMIT_STEP(CS_LIMIT_STEP), .LATCHED_OFF(LATCHED_OFF),
  .VALLEY_COUNT(VALLEY_COUNT), .ZC_COUNT(ZC_COUNT));

// ---- tb/vsfr_plant.sv ----
// Behavioural model of the current comparator and the ringing winding.
// Assumes the bench drives every comparator level that this model does not.
`timescale 1ns/1ps
module vsfr_plant (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       gate,
  input  wire logic [7:0] on_len,
  input  wire logic [4:0] ring_n,
  output logic            cs_trip,
  output logic            below_zero
);
  typedef struct packed {
    logic [7:0] t;
    logic       g;
    logic       trip;
    logic       below;
  } vsfr_plant_t;
  vsfr_plant_t s_r;
  vsfr_plant_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.g = gate;
    s_nxt.t = (gate != s_r.g) ? 8'h0 : s_r.t + {7'h0, ~&s_r.t};
    s_nxt.trip = gate && (s_r.t >= on_len);
    // damped ringing
    // One half-wave every 8 cycles; the ringing dies after ring_n crossings.
    s_nxt.below = !gate && s_r.t[2] && (s_r.t < {ring_n, 3'h0});
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign cs_trip    = s_r.trip;
  assign below_zero = s_r.below;
endmodule

// ---- tb/vsfr_core_tb_top.sv ----
// Self-checking bench for the valley-switching core with shortened timers.
// Assumes the plant model answers the gate; the bench drives all other inputs.
`timescale 1ns/1ps
module vsfr_core_tb_top;
  localparam int EVAL   = 200;
  localparam int SSTEP  = 50;
  localparam int MAXOFF = 300;
  localparam int RSS    = 50;
  localparam int RSL    = 100;
  localparam int OVP    = 20;
  // Feedback code of each period, two bits each from the low end.
  localparam logic [23:0] SEQ = 24'h1b9000;
  logic       CLK, RESETN, FB_ABOVE_LOW, FB_ABOVE_HIGH, FB_ABOVE_RESET, LINE_HIGH;
  logic       ZC_BELOW_ZERO, ZC_ABOVE_OVP, ZC_ABOVE_RS, SUPPLY_ON, CS_TRIP;
  logic       GATE_DRIVE, PRECHARGE_EN, SOFTSTART_DONE, LATCHED_OFF, THR_SEL_HIGH_LINE;
  logic [1:0] CS_LIMIT_STEP;
  logic [2:0] VALLEY_COUNT, ZC_COUNT, v;
  logic [4:0] ring;
  int         num_errors = 0;
  int         checked    = 0;
  int         cyc        = 0;
  int         t0         = 0;
  int         pk         = 1;

  vsfr_core #(.EVAL_CYC(EVAL), .SS_STEP_CYC(SSTEP), .MAX_OFF_CYC(MAXOFF), .RS_SHORT_CYC(RSS),
    .RS_LONG_CYC(RSL), .LEB_CYC(6), .OVP_CYC(OVP)) dut (.CLK(CLK), .RESETN(RESETN),
    .FB_ABOVE_LOW(FB_ABOVE_LOW), .FB_ABOVE_HIGH(FB_ABOVE_HIGH), .FB_ABOVE_RESET(FB_ABOVE_RESET),
    .LINE_HIGH(LINE_HIGH), .ZC_BELOW_ZERO(ZC_BELOW_ZERO), .ZC_ABOVE_OVP(ZC_ABOVE_OVP),
    .ZC_ABOVE_RS(ZC_ABOVE_RS), .SUPPLY_ON(SUPPLY_ON), .CS_TRIP(CS_TRIP),
    .GATE_DRIVE(GATE_DRIVE), .PRECHARGE_EN(PRECHARGE_EN), .CS_LIMIT_STEP(CS_LIMIT_STEP),
    .SOFTSTART_DONE(SOFTSTART_DONE), .LATCHED_OFF(LATCHED_OFF), .VALLEY_COUNT(VALLEY_COUNT),
    .ZC_COUNT(ZC_COUNT), .THR_SEL_HIGH_LINE(THR_SEL_HIGH_LINE));
  vsfr_plant u_plant (.clk(CLK), .rst_n(RESETN), .gate(GATE_DRIVE), .on_len(8'h14),
    .ring_n(ring), .cs_trip(CS_TRIP), .below_zero(ZC_BELOW_ZERO));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) cyc <= cyc + 1;

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    // An unknown value must count as a miss, so the result is compared with 4-state equality.
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_to(input int tgt);
    while (cyc < tgt) begin
      @(posedge CLK);
      #1;
    end
  endtask
  // A missed gate edge means a hang, so the run is closed at once.
  task automatic wait_gate(input logic val);
    for (int i = 0; i < 2000 && GATE_DRIVE !== val; i++) begin
      @(posedge CLK);
      #1;
    end
    if (GATE_DRIVE !== val) begin
      chk(GATE_DRIVE, val);
      print_verdict();
    end
  endtask
  task automatic measure_off(output logic [15:0] n, output logic [2:0] last);
    wait_gate(1'b1);
    wait_gate(1'b0);
    n = 16'h0;
    last = ZC_COUNT;
    while (GATE_DRIVE === 1'b0 && n < 16'h7d0) begin
      last = ZC_COUNT;
      n++;
      @(posedge CLK);
      #1;
    end
  endtask

  task automatic t_reset;
    #1;
    chk(GATE_DRIVE, 1'b0);
    chk(VALLEY_COUNT, 3'h1);
    chk(ZC_COUNT, 3'h0);
    @(posedge CLK);
    RESETN <= 1'b1;
    repeat (50) @(posedge CLK);
    #1;
    chk({PRECHARGE_EN, GATE_DRIVE}, 2'h2);
    $display("test reset done");
  endtask
  task automatic t_startup;
    @(posedge CLK);
    SUPPLY_ON <= 1'b1;
    wait_gate(1'b1);
    t0 = cyc;
    chk(PRECHARGE_EN, 1'b0);
    $display("test startup done");
  endtask
  task automatic t_softstart;
    for (int k = 0; k < 4; k++) begin
      wait_to(t0 + SSTEP * k + 25);
      chk(CS_LIMIT_STEP, k[15:0]);
    end
    chk(SOFTSTART_DONE, 1'b0);
    wait_to(t0 + 4 * SSTEP + 25);
    chk(SOFTSTART_DONE, 1'b1);
    chk(VALLEY_COUNT, 3'h2);
    v = 3'h2;
    $display("test softstart done");
  endtask
  task automatic t_period(input logic [1:0] code, input logic line);
    logic [2:0] old;
    old = v;
    wait_to(t0 + EVAL * pk + 80);
    @(posedge CLK);
    FB_ABOVE_LOW <= code != 2'h0;
    FB_ABOVE_HIGH <= code[1];
    FB_ABOVE_RESET <= code == 2'h3;
    LINE_HIGH <= line;
    repeat (10) @(posedge CLK);
    FB_ABOVE_LOW <= 1'b0;
    FB_ABOVE_HIGH <= 1'b0;
    FB_ABOVE_RESET <= 1'b0;
    wait_to(t0 + EVAL * pk + 190);
    chk(VALLEY_COUNT, old);
    case (code)
      2'h0: v = (v < 3'h7) ? v + 3'h1 : v;
      2'h2: v = (v > 3'h1) ? v - 3'h1 : v;
      2'h3: v = 3'h1;
      default: v = v;
    endcase
    pk++;
    wait_to(t0 + EVAL * pk + 100);
    chk(VALLEY_COUNT, v);
    chk(THR_SEL_HIGH_LINE, line);
    $display("test period code %0d done", code);
  endtask
  task automatic t_switch(input logic rs, input logic [4:0] rg, input logic [15:0] lo,
                          input logic [15:0] hi, input logic [2:0] cnt);
    logic [15:0] n;
    logic [2:0]  last;
    @(posedge CLK);
    ZC_ABOVE_RS <= rs;
    ring <= rg;
    measure_off(n, last);
    measure_off(n, last);
    rng(n, lo, hi);
    chk(last, cnt);
    $display("test switching done");
  endtask
  task automatic t_ovp;
    logic [15:0] k;
    wait_gate(1'b1);
    wait_gate(1'b0);
    repeat (5) @(posedge CLK);
    ZC_ABOVE_OVP <= 1'b1;
    repeat (OVP - 5) @(posedge CLK);
    ZC_ABOVE_OVP <= 1'b0;
    repeat (10) @(posedge CLK);
    ZC_ABOVE_OVP <= 1'b1;
    #1;
    chk(LATCHED_OFF, 1'b0);
    for (k = 16'h0; k < 16'h64 && LATCHED_OFF !== 1'b1; k++) begin
      @(posedge CLK);
      #1;
    end
    rng(k, 16'(OVP), 16'(OVP + 4));
    @(posedge CLK);
    ZC_ABOVE_OVP <= 1'b0;
    repeat (400) @(posedge CLK);
    #1;
    chk({LATCHED_OFF, GATE_DRIVE}, 2'h2);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (8) @(posedge CLK);
    #1;
    chk({LATCHED_OFF, VALLEY_COUNT}, 4'h1);
    $display("test latch-off done");
  endtask

  initial begin
    {RESETN, FB_ABOVE_LOW, FB_ABOVE_HIGH, FB_ABOVE_RESET, LINE_HIGH} = 5'h0;
    {ZC_ABOVE_OVP, ZC_ABOVE_RS, SUPPLY_ON} = 3'h0;
    ring = 5'h0;
    v = 3'h1;
    repeat (8) @(posedge CLK);
    t_reset();
    t_startup();
    t_softstart();
    for (int i = 0; i < 12; i++) begin
      t_period(SEQ[2 * i +: 2], i >= 6);
    end
    @(posedge CLK);
    FB_ABOVE_LOW <= 1'b1;
    t_switch(1'b0, 5'hc, 16'(RSL - 1), 16'(RSL + 4), 3'h7);
    t_switch(1'b1, 5'h2, 16'(RSS - 1), 16'(RSS + 4), 3'h2);
    t_switch(1'b1, 5'h1, 16'(MAXOFF - 1), 16'(MAXOFF + 4), 3'h1);
    t_ovp();
    print_verdict();
  end
endmodule
